// [rtl/acw_defines.svh]
// constants of the control word register bank
`ifndef ACW_DEFINES_SVH
`define ACW_DEFINES_SVH
`define ACW_NUM_CR        6
`define ACW_ADC_PAIRS     3
`define ACW_IDX_MODE      3'h0
`define ACW_IDX_CLK       3'h1
`define ACW_IDX_PWR       3'h2
`define ACW_IDX_PAIR1     3'h3
`define ACW_CR_RST        8'h00
`define ACW_SRST_BIT      7
`define ACW_SRST_DMCLKS   3'h4
`define ACW_DEV_SELF      3'h0
`define ACW_WORD_LAST     4'hF
`define ACW_MDIV_LAST     3'h4
`define ACW_SCLK_HALF_MAX 4'h8
`define ACW_DEC_MAX       12'h800
`endif

// [rtl/acw_pkg.sv]
// types of the control word register bank
package acw_pkg;
  typedef struct packed {
    logic       srst;
    logic [2:0] cascade_count_field;
    logic       serial_loopback_enable;
    logic       rsvd;
    logic       mixed_mode_enable;
    logic       operating_mode_select;
  } acw_mode_s;
  typedef struct packed {
    logic       echo_enable;
    logic [2:0] master_clock_select;
    logic [1:0] serial_clock_select;
    logic [1:0] decimation_select;
  } acw_clk_s;
  typedef struct packed {
    logic       rsvd_hi;
    logic       reference_output_enable;
    logic       reference_power_on;
    logic [3:0] rsvd_lo;
    logic       global_power_on;
  } acw_pwr_s;
  typedef struct packed {
    logic       even_adc_power_on;
    logic [2:0] even_adc_gain_select;
    logic       odd_adc_power_on;
    logic [2:0] odd_adc_gain_select;
  } acw_pair_s;
  typedef struct packed {
    acw_mode_s            mode;
    acw_clk_s             clk;
    acw_pwr_s             pwr;
    acw_pair_s [2:0]      pair;
  } acw_cfg_s;
  typedef struct packed {
    logic       ctrl;
    logic       rd;
    logic [2:0] dev;
    logic [2:0] reg_addr;
    logic [7:0] data;
  } acw_word_s;
  typedef enum logic [1:0] {
    ACW_RX_IDLE  = 2'b01,
    ACW_RX_SHIFT = 2'b10
  } acw_rx_e;
  typedef enum logic [2:0] {
    ACW_TX_IDLE  = 3'b001,
    ACW_TX_FSYNC = 3'b010,
    ACW_TX_SEND  = 3'b100
  } acw_tx_e;
endpackage

// [rtl/acw_regbank.sv]
// serial control word decoder and control register bank
`timescale 1ns/10ps
`include "acw_defines.svh"
module acw_regbank (
  input  wire logic             CORE_CLK,
  input  wire logic             NRST,
  input  wire logic             SDI,
  input  wire logic             SDIFS,
  output logic                  SCLK,
  output logic                  SDO,
  output logic                  SDOFS,
  output acw_pkg::acw_cfg_s     CFG,
  output logic                  SAMPLE_TICK,
  output logic [5:0]            ADC_POWERED,
  output logic                  REF_POWERED,
  output logic                  REFERENCE_OUTPUT_PIN_EN,
  output logic                  RESET_BUSY
);
  import acw_pkg::*;

  logic            sdi_s1_r;
  logic            sdi_s2_r;
  logic            fs_s1_r;
  logic            fs_s2_r;
  logic [2:0]      mcnt_r;
  logic [3:0]      scnt_r;
  logic [10:0]     dcnt_r;
  logic            sclk_r;
  logic            sample_r;
  logic [2:0]      srst_cnt_r;
  acw_rx_e         rx_state_r;
  logic [3:0]      rx_cnt_r;
  logic [15:0]     rx_sh_r;
  acw_tx_e         tx_state_r;
  logic [3:0]      tx_cnt_r;
  logic [15:0]     tx_sh_r;
  logic            tx_pend_r;
  logic [15:0]     tx_word_r;
  logic            sdo_r;
  logic            sdofs_r;
  logic [5:0]      adc_pwr_r;
  logic            ref_pwr_r;
  logic            reference_output_pin_r;
  logic [7:0]      cr_w [0:5];
  acw_mode_s       mode;
  acw_clk_s        clkc;
  acw_pwr_s        pwr;
  logic [2:0]      mdiv_top;
  logic            dm_tick;
  logic [3:0]      half_top;
  logic            half_tick;
  logic            fall_tick;
  logic            rise_tick;
  logic [10:0]     dec_top;
  logic            busy;
  logic            word_done;
  acw_word_s       rx_word;
  logic            in_prog;
  logic            in_mixed;
  logic            ctrl_ok;
  logic            mine;
  logic            do_write;
  logic            do_read;
  logic            do_fwd;
  logic            do_echo;
  logic            do_loop;
  logic            tx_req;
  logic [7:0]      rd_data;
  logic [15:0]     tx_nxt;
  logic            srst_hit;
  logic [47:0]     cr_flat;

  // pin synchronisers
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      sdi_s1_r <= 1'b0;
      sdi_s2_r <= 1'b0;
      fs_s1_r  <= 1'b0;
      fs_s2_r  <= 1'b0;
    end else begin
      sdi_s1_r <= SDI;
      sdi_s2_r <= sdi_s1_r;
      fs_s1_r  <= SDIFS;
      fs_s2_r  <= fs_s1_r;
    end
  end

  assign mode = acw_mode_s'(cr_w[0]);
  assign clkc = acw_clk_s'(cr_w[1]);
  assign pwr  = acw_pwr_s'(cr_w[2]);
  assign CFG  = {cr_w[0], cr_w[1], cr_w[2], cr_w[5], cr_w[4], cr_w[3]};
  assign cr_flat = {cr_w[0], cr_w[1], cr_w[2], cr_w[3], cr_w[4], cr_w[5]};

  // internal master clock divider
  assign mdiv_top = (clkc.master_clock_select <= `ACW_MDIV_LAST) ?
                    clkc.master_clock_select : 3'h0;
  assign dm_tick  = (mcnt_r >= mdiv_top);

  // serial clock, bit period twice the selected divide of internal ticks
  assign half_top  = (`ACW_SCLK_HALF_MAX >> clkc.serial_clock_select) - 4'h1;
  assign half_tick = dm_tick && (scnt_r >= half_top);
  assign fall_tick = half_tick && sclk_r;
  assign rise_tick = half_tick && !sclk_r;

  // sample event divider
  assign dec_top = 11'((`ACW_DEC_MAX >> clkc.decimation_select) - 12'h1);

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      mcnt_r   <= 3'h0;
      scnt_r   <= 4'h0;
      dcnt_r   <= 11'h0;
      sclk_r   <= 1'b0;
      sample_r <= 1'b0;
    end else begin
      mcnt_r   <= dm_tick ? 3'h0 : mcnt_r + 3'h1;
      if (dm_tick) begin
        scnt_r <= half_tick ? 4'h0 : scnt_r + 4'h1;
        dcnt_r <= (dcnt_r >= dec_top) ? 11'h0 : dcnt_r + 11'h1;
      end
      if (half_tick) begin
        sclk_r <= !sclk_r;
      end
      sample_r <= dm_tick && (dcnt_r >= dec_top);
    end
  end

  // software and hardware reset sequencing
  assign busy     = (srst_cnt_r != 3'h0);
  assign srst_hit = do_write && (rx_word.reg_addr == `ACW_IDX_MODE) &&
                    rx_word.data[`ACW_SRST_BIT];

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      srst_cnt_r <= `ACW_SRST_DMCLKS;
    end else if (srst_hit) begin
      srst_cnt_r <= `ACW_SRST_DMCLKS;
    end else if (busy && dm_tick) begin
      srst_cnt_r <= srst_cnt_r - 3'h1;
    end
  end

  // receive shifter, samples on the falling serial edge
  assign word_done = (rx_state_r == ACW_RX_SHIFT) && fall_tick &&
                     (rx_cnt_r == `ACW_WORD_LAST);
  assign rx_word   = acw_word_s'({rx_sh_r[14:0], sdi_s2_r});

  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      rx_state_r <= ACW_RX_IDLE;
      rx_cnt_r   <= 4'h0;
      rx_sh_r    <= 16'h0000;
    end else if (fall_tick) begin
      case (rx_state_r)
        ACW_RX_IDLE: begin
          rx_cnt_r <= 4'h0;
          if (fs_s2_r) begin
            rx_state_r <= ACW_RX_SHIFT;
          end
        end
        ACW_RX_SHIFT: begin
          rx_sh_r  <= {rx_sh_r[14:0], sdi_s2_r};
          rx_cnt_r <= rx_cnt_r + 4'h1;
          if (rx_cnt_r == `ACW_WORD_LAST) begin
            rx_state_r <= ACW_RX_IDLE;
          end
        end
        default: begin
          rx_state_r <= ACW_RX_IDLE;
        end
      endcase
    end
  end

  // word decode
  assign in_prog  = !mode.operating_mode_select;
  assign in_mixed = mode.operating_mode_select && mode.mixed_mode_enable;
  assign ctrl_ok  = word_done && rx_word.ctrl && (in_prog || in_mixed) && !busy;
  assign mine     = (rx_word.dev == `ACW_DEV_SELF);
  assign do_write = ctrl_ok && mine && !rx_word.rd;
  assign do_read  = ctrl_ok && mine && rx_word.rd;
  assign do_fwd   = ctrl_ok && !mine;
  assign do_echo  = do_write && clkc.echo_enable;
  assign do_loop  = word_done && mode.serial_loopback_enable && !busy;
  assign tx_req   = do_fwd || do_read || do_echo || do_loop;
  assign rd_data  = (rx_word.reg_addr < 3'(`ACW_NUM_CR)) ?
                    cr_w[rx_word.reg_addr] : `ACW_CR_RST;

  always_comb begin
    tx_nxt = rx_word;
    if (do_fwd) begin
      tx_nxt[13:11] = rx_word.dev - 3'h1;
    end else if (do_read) begin
      tx_nxt[7:0] = rd_data;
    end
  end

  // control registers, one per implemented index
  genvar gi;
  generate
    for (gi = 0; gi < `ACW_NUM_CR; gi++) begin : g_cr
      logic [7:0] q_r;
      always_ff @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
          q_r <= `ACW_CR_RST;
        end else if (busy) begin
          q_r <= `ACW_CR_RST;
        end else if (do_write && (rx_word.reg_addr == 3'(gi))) begin
          q_r <= rx_word.data;
        end
      end
      assign cr_w[gi] = q_r;
    end
  endgenerate

  // transmit, frame sync bit then sixteen bits on rising serial edges
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      tx_pend_r  <= 1'b0;
      tx_word_r  <= 16'h0000;
      tx_state_r <= ACW_TX_IDLE;
      tx_cnt_r   <= 4'h0;
      tx_sh_r    <= 16'h0000;
      sdo_r      <= 1'b0;
      sdofs_r    <= 1'b0;
    end else begin
      if (tx_req && !tx_pend_r) begin
        tx_pend_r <= 1'b1;
        tx_word_r <= tx_nxt;
      end else if (rise_tick && (tx_state_r == ACW_TX_IDLE) && tx_pend_r) begin
        tx_pend_r <= 1'b0;
      end
      if (rise_tick) begin
        case (tx_state_r)
          ACW_TX_IDLE: begin
            sdo_r <= 1'b0;
            if (tx_pend_r) begin
              tx_state_r <= ACW_TX_FSYNC;
              sdofs_r    <= 1'b1;
              tx_sh_r    <= tx_word_r;
            end
          end
          ACW_TX_FSYNC: begin
            tx_state_r <= ACW_TX_SEND;
            sdofs_r    <= 1'b0;
            sdo_r      <= tx_sh_r[15];
            tx_sh_r    <= {tx_sh_r[14:0], 1'b0};
            tx_cnt_r   <= 4'h0;
          end
          ACW_TX_SEND: begin
            tx_cnt_r <= tx_cnt_r + 4'h1;
            sdo_r    <= tx_sh_r[15];
            tx_sh_r  <= {tx_sh_r[14:0], 1'b0};
            if (tx_cnt_r == `ACW_WORD_LAST) begin
              tx_state_r <= ACW_TX_IDLE;
              sdo_r      <= 1'b0;
            end
          end
          default: begin
            tx_state_r <= ACW_TX_IDLE;
          end
        endcase
      end
    end
  end

  // power outputs, global on overrides individual power-on bits but not the reference output enable
  always_ff @(posedge CORE_CLK or negedge NRST) begin
    if (!NRST) begin
      adc_pwr_r <= 6'h00;
      ref_pwr_r <= 1'b0;
      reference_output_pin_r  <= 1'b0;
    end else begin
      for (int k = 0; k < `ACW_ADC_PAIRS; k++) begin
        adc_pwr_r[2*k]   <= pwr.global_power_on || CFG.pair[k].odd_adc_power_on;
        adc_pwr_r[2*k+1] <= pwr.global_power_on || CFG.pair[k].even_adc_power_on;
      end
      ref_pwr_r <= pwr.global_power_on || pwr.reference_power_on;
      reference_output_pin_r  <= pwr.reference_output_enable;
    end
  end

  assign SCLK        = sclk_r;
  assign SDO         = sdo_r;
  assign SDOFS       = sdofs_r;
  assign SAMPLE_TICK = sample_r;
  assign ADC_POWERED = adc_pwr_r;
  assign REF_POWERED = ref_pwr_r;
  assign REFERENCE_OUTPUT_PIN_EN   = reference_output_pin_r;
  assign RESET_BUSY  = busy;

  default clocking cb @(posedge CORE_CLK); endclocking
  default disable iff (!NRST);

  sequence s_srst_req;
    srst_hit;
  endsequence
  sequence s_srst_run;
    busy ##1 (cr_flat == 48'h0);
  endsequence

  invalid_word_drop_a: assert property (
    word_done && !rx_word.ctrl && in_prog |=> $stable(cr_flat))
    else $error("invalid control word changed a register");
  reg_write_store_a: assert property (
    do_write && (rx_word.reg_addr != `ACW_IDX_MODE) &&
    (rx_word.reg_addr < 3'(`ACW_NUM_CR)) |=>
    cr_w[$past(rx_word.reg_addr)] == $past(rx_word.data))
    else $error("written data not stored");
  read_reply_a: assert property (
    do_read && !tx_pend_r |=> tx_pend_r && (tx_word_r[7:0] == $past(rd_data)))
    else $error("read reply missing register value");
  fwd_decrement_a: assert property (
    do_fwd && !tx_pend_r |=> tx_word_r[13:11] == $past(rx_word.dev) - 3'h1)
    else $error("forwarded address not decremented");
  data_mode_ignore_a: assert property (
    word_done && mode.operating_mode_select && !mode.mixed_mode_enable
    |=> $stable(cr_flat))
    else $error("data mode accepted a control word");
  srst_clear_a: assert property (
    s_srst_req |=> s_srst_run)
    else $error("software reset did not clear registers");
  reset_length_a: assert property (
    $rose(busy) && (mdiv_top == 3'h0) && (mcnt_r == 3'h0) |-> busy [*4] ##1 !busy)
    else $error("reset did not last four internal clocks");
  sclk_fast_a: assert property (
    (clkc.serial_clock_select == 2'h3) && (mdiv_top == 3'h0) && rise_tick
    && !busy |=> fall_tick)
    else $error("undivided serial clock wrong");
  adc_power_a: assert property (
    !busy |=> ADC_POWERED[0] ==
    ($past(pwr.global_power_on) || $past(cr_w[3][3])))
    else $error("first converter power wrong");
  echo_word_a: assert property (
    do_echo && !tx_pend_r |=> tx_pend_r && (tx_word_r == $past(rx_word)))
    else $error("echoed word differs from received word");
  loop_word_a: assert property (
    do_loop && !do_fwd && !do_read && !tx_pend_r |=> tx_word_r == $past(rx_word))
    else $error("looped word differs from received word");
  ref_power_a: assert property (
    !busy |=> REF_POWERED ==
    ($past(pwr.global_power_on) || $past(pwr.reference_power_on)))
    else $error("reference power wrong");
  reference_output_pin_enable_a: assert property (
    !busy |=> REFERENCE_OUTPUT_PIN_EN == $past(pwr.reference_output_enable))
    else $error("reference output enable wrong");
  last_adc_power_a: assert property (
    !busy |=> ADC_POWERED[5] ==
    ($past(pwr.global_power_on) || $past(cr_w[5][7])))
    else $error("last converter power wrong");
endmodule

// [verification/acw_host_model.sv]
// host serial port model driving control frames
`timescale 1ns/10ps
module acw_host_model (
  input  wire logic CORE_CLK,
  input  wire logic SCLK,
  input  wire logic SDO,
  input  wire logic SDOFS,
  output logic      SDI,
  output logic      SDIFS
);
  logic [15:0] rx_q[$];
  logic [15:0] rx_w;
  initial begin
    SDI = 1'b1;
    SDIFS = 1'b0;
  end
  // change lines just after serial clock fall
  task automatic slot(input logic fs, input logic d);
    @(negedge SCLK);
    @(negedge CORE_CLK);
    SDIFS = fs;
    SDI = d;
  endtask
  // sync bit, 16 bits msb first, then release
  task automatic send_word(input logic [15:0] w);
    slot(1'b1, ~w[15]);
    for (int i = 15; i >= 0; i--) slot(1'b0, w[i]);
    slot(1'b0, ~w[0]);
  endtask
  // capture replies mid bit period
  always @(negedge SCLK) begin
    if (SDOFS === 1'b1) begin
      for (int i = 15; i >= 0; i--) begin
        @(negedge SCLK);
        rx_w[i] = SDO;
      end
      rx_q.push_back(rx_w);
    end
  end
endmodule

// [verification/testbench.sv]
// self-checking bench of the control word register bank
`timescale 1ns/10ps
`define CHK(a, e) begin total_checks++; if ((a) !== (e)) begin num_errors++; \
  $display("ERROR %0t got %0h exp %0h", $time, a, e); end end
module testbench;
  import acw_pkg::*;
  logic             CORE_CLK = 1'b0;
  logic             NRST = 1'b0;
  logic             SDI, SDIFS, SCLK, SDO, SDOFS;
  acw_cfg_s         CFG;
  logic             SAMPLE_TICK, REF_POWERED, REFERENCE_OUTPUT_PIN_EN, RESET_BUSY;
  logic [5:0]       ADC_POWERED;
  int               num_errors = 0;
  int               total_checks = 0;
  int               cycles = 0;
  int               n;
  always #20 CORE_CLK = ~CORE_CLK;
  acw_regbank acw_regbank_inst (.CORE_CLK(CORE_CLK), .NRST(NRST), .SDI(SDI),
    .SDIFS(SDIFS), .SCLK(SCLK), .SDO(SDO), .SDOFS(SDOFS), .CFG(CFG),
    .SAMPLE_TICK(SAMPLE_TICK), .ADC_POWERED(ADC_POWERED),
    .REF_POWERED(REF_POWERED), .REFERENCE_OUTPUT_PIN_EN(REFERENCE_OUTPUT_PIN_EN), .RESET_BUSY(RESET_BUSY));
  acw_host_model acw_host_model_inst (.CORE_CLK(CORE_CLK), .SCLK(SCLK), .SDO(SDO),
    .SDOFS(SDOFS), .SDI(SDI), .SDIFS(SDIFS));
  task automatic finish_test();
    $display("checks %0d errors %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask
  always @(posedge CORE_CLK) begin
    cycles++;
    if (cycles == 80000) begin
      num_errors++;
      finish_test();
    end
  end
  function automatic logic [15:0] cw(logic rd, logic [2:0] dv, logic [2:0] ra,
                                     logic [7:0] d);
    return {1'b1, rd, dv, ra, d};
  endfunction
  task automatic xfer(input logic [15:0] w);
    acw_host_model_inst.send_word(w);
    repeat (4) @(negedge CORE_CLK);
  endtask
  // wait bounded for a reply, check count and word
  task automatic reply(input int cnt, input logic [15:0] e);
    int k;
    k = 0;
    while ((acw_host_model_inst.rx_q.size() == 0 || cnt == 0) && k < 600) begin
      @(negedge CORE_CLK);
      k++;
    end
    `CHK(acw_host_model_inst.rx_q.size(), cnt)
    if (acw_host_model_inst.rx_q.size() > 0) `CHK(acw_host_model_inst.rx_q.pop_front(), e)
  endtask
  task automatic drain();
    repeat (600) @(negedge CORE_CLK);
    acw_host_model_inst.rx_q.delete();
  endtask
  // cycles up to next rising edge of tick or serial clock
  task automatic rise(input bit tk, output int c);
    logic p;
    c = 0;
    p = 1'b1;
    forever begin
      @(negedge CORE_CLK);
      c++;
      if ((tk ? SAMPLE_TICK : SCLK) === 1'b1 && p === 1'b0) break;
      p = tk ? SAMPLE_TICK : SCLK;
      if (c > 5000) break;
    end
  endtask
  task automatic per(input bit tk, input int e);
    rise(tk, n);
    rise(tk, n);
    `CHK(n, e)
  endtask
  task automatic hw_reset();
    NRST = 1'b0;
    repeat (12) @(negedge CORE_CLK);
    `CHK(RESET_BUSY, 1'b1)
    NRST = 1'b1;
    repeat (2) @(negedge CORE_CLK);
    `CHK(RESET_BUSY, 1'b1)
    repeat (4) @(negedge CORE_CLK);
    `CHK(RESET_BUSY, 1'b0)
    `CHK(CFG, '0)
    acw_host_model_inst.rx_q.delete();
  endtask
  initial begin
    hw_reset();
    per(1'b1, 2048);
    xfer(cw(0, 0, 3'h2, 8'h60));
    `CHK(CFG.pwr, 8'h60)
    `CHK({REF_POWERED, REFERENCE_OUTPUT_PIN_EN, ADC_POWERED}, 8'hC0)
    xfer(cw(0, 0, 3'h3, 8'h0A));
    xfer(cw(0, 0, 3'h4, 8'hD0));
    xfer(cw(0, 0, 3'h5, 8'h07));
    `CHK(CFG.pair, 24'h07D00A)
    `CHK(ADC_POWERED, 6'b001001)
    xfer(cw(0, 0, 3'h2, 8'h01));
    `CHK({REF_POWERED, REFERENCE_OUTPUT_PIN_EN, ADC_POWERED}, 8'hBF)
    xfer(cw(1, 0, 3'h4, 8'h00));
    reply(1, cw(1, 0, 3'h4, 8'hD0));
    xfer(cw(0, 3'h5, 3'h3, 8'hFF));
    reply(1, cw(0, 3'h4, 3'h3, 8'hFF));
    `CHK(CFG.pair[0], 8'h0A)
    xfer(16'h0355);
    reply(0, 16'h0000);
    `CHK(CFG.pair[0], 8'h0A)
    xfer(cw(0, 0, 3'h6, 8'h5A));
    xfer(cw(1, 0, 3'h6, 8'h00));
    reply(1, cw(1, 0, 3'h6, 8'h00));
    xfer(cw(0, 0, 3'h1, 8'h80));
    xfer(cw(0, 0, 3'h1, 8'h07));
    reply(1, cw(0, 0, 3'h1, 8'h07));
    drain();
    `CHK(CFG.clk, 8'h07)
    per(1'b0, 8);
    per(1'b1, 256);
    xfer(cw(0, 0, 3'h1, 8'h13));
    per(1'b0, 32);
    per(1'b1, 512);
    xfer(cw(0, 0, 3'h1, 8'h50));
    per(1'b0, 16);
    xfer(cw(0, 0, 3'h0, 8'h78));
    `CHK(CFG.mode.cascade_count_field, 3'h7)
    drain();
    xfer(cw(0, 0, 3'h5, 8'h33));
    reply(1, cw(0, 0, 3'h5, 8'h33));
    xfer(cw(0, 0, 3'h0, 8'h03));
    drain();
    xfer(cw(0, 0, 3'h5, 8'h44));
    `CHK(CFG.pair[2], 8'h44)
    xfer(16'h0522);
    `CHK(CFG.pair[2], 8'h44)
    xfer(cw(0, 0, 3'h0, 8'h01));
    xfer(cw(0, 0, 3'h5, 8'h66));
    `CHK(CFG.pair[2], 8'h44)
    hw_reset();
    xfer(cw(0, 0, 3'h3, 8'h11));
    acw_host_model_inst.send_word(cw(0, 0, 3'h0, 8'h80));
    n = 0;
    while (RESET_BUSY !== 1'b1 && n < 40) begin
      @(negedge CORE_CLK);
      n++;
    end
    `CHK(RESET_BUSY, 1'b1)
    repeat (8) @(negedge CORE_CLK);
    `CHK(RESET_BUSY, 1'b0)
    `CHK(CFG, '0)
    xfer(cw(0, 0, 3'h1, 8'h26));
    per(1'b0, 24);
    per(1'b1, 1536);
    xfer(cw(0, 0, 3'h1, 8'h39));
    per(1'b0, 16);
    per(1'b1, 4096);
    xfer(cw(0, 0, 3'h1, 8'h4C));
    per(1'b0, 10);
    xfer(cw(0, 0, 3'h1, 8'h0C));
    per(1'b0, 2);
    finish_test();
  end
endmodule
